// *** verilog/host_byte_port_consts.svh ***
// Constants for the host byte port: selects, bit positions, reset values.
`ifndef HOST_BYTE_PORT_CONSTS_SVH
`define HOST_BYTE_PORT_CONSTS_SVH
`define SEL_CTRL 2'h0
`define SEL_DATA_INC 2'h1
`define SEL_PTR 2'h2
`define SEL_DATA_KEEP 2'h3
`define CTL_BOB 0
`define CTL_SHARED 1
`define CTL_CORE_IRQ 2
`define CTL_CORE_TO_HOST_IRQ 3
`define CTL_RSVD_HI 7
`define CTL_RSVD_LO 4
`define MEM_IDX_W 11
`define PTR_W 16
`define PTR_RST 16'h0000
`define PTR_STEP 16'h0001
`define BOB_RST 1'h0
`define CORE_TO_HOST_IRQ_RST 1'h0
`define SHARED_IN_RST 1'h0
`define SHARED_AFTER_RST 1'h1
`define BYTE_FIRST 1'h0
`define BYTE_SECOND 1'h1
`define DIR_READ 1'h1
`define DIR_WRITE 1'h0
`define FIFO_DEPTH 8
`endif

// *** verilog/host_byte_port_pkg.sv ***
// Types shared by the host byte port design.
`default_nettype none
package host_byte_port_pkg;
    typedef enum logic [1:0] {
        ENG_IDLE = 2'b00,
        ENG_READ = 2'b01,
        ENG_LOAD = 2'b10
    } eng_state_t;
    typedef logic [1:0] reg_sel_t;
endpackage : host_byte_port_pkg
`default_nettype wire

// *** verilog/host_byte_port.sv ***
// Host byte port: pin decode, registers, shared memory and write FIFO.
`timescale 1ns/1ps
`include "host_byte_port_consts.svh"
`default_nettype none

module word_fifo #(
    parameter int WIDTH = 27,
    parameter int DEPTH = `FIFO_DEPTH
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Fill side
    input wire logic i_valid,
    output logic o_ready,
    input wire logic [WIDTH-1:0] i_data,
    // Drain side
    output logic o_valid,
    input wire logic i_ready,
    output logic [WIDTH-1:0] o_data
);
    localparam int AW = $clog2(DEPTH);
    logic [WIDTH-1:0] store [DEPTH];
    logic [AW-1:0] wr_ptr;
    logic [AW-1:0] rd_ptr;
    logic [AW:0] count;
    logic push;
    logic pop;

    assign o_ready = (count != (AW+1)'(DEPTH));
    assign o_valid = (count != '0);
    assign o_data = store[rd_ptr];
    assign push = i_valid & o_ready;
    assign pop = o_valid & i_ready;

    always_ff @(posedge i_sys_clk)
    begin
        if (push)
        begin
            store[wr_ptr] <= i_data;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            wr_ptr <= '0;
            rd_ptr <= '0;
            count <= '0;
        end
        else
        begin
            if (push)
            begin
                wr_ptr <= (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
            end
            if (pop)
            begin
                rd_ptr <= (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;
            end
            if (push && !pop)
            begin
                count <= count + 1'b1;
            end
            else if (pop && !push)
            begin
                count <= count - 1'b1;
            end
        end
    end
endmodule : word_fifo

// Functional notes
// - Ready high when idle, low while busy.
// - Ready forced high while port deselected.
// - Last of select and strobes samples inputs.
// - Data strobes combined so both-low is idle.
// - Address-strobe latched fields held for access.
// - Select 00 reaches the control register.
// - Select 01 data, read post-increment, write pre-increment.
// - Select 10 reaches the memory pointer.
// - Select 11 data, pointer left unchanged.
// - Low 11 pointer bits index 2K words.
// - Pointer is 16 bits, fully read/write.
// - Increment spans all 16 pointer bits.
// - Control register bytes mirror each other.
// - Four control bits in low positions.
// - Reserved control bits ignored on write.
// - Bits defined as zero always read zero.
// - Address strobe falling edge latches inputs.
// - Byte order bit picks first byte significance.
// - Writing one raises core interrupt pulse.
// - Core sets host interrupt; host one clears.
module host_byte_port #(
    parameter int DATA_W = 16,
    parameter int MEM_WORDS = 2048
) (
    // Clock and reset
    input wire logic i_sys_clk,
    input wire logic i_rst,
    // Host pins
    input wire logic i_port_select_n,
    input wire logic i_data_strobe_a,
    input wire logic i_data_strobe_b,
    input wire logic i_addr_strobe_n,
    input wire logic i_reg_select_lo,
    input wire logic i_reg_select_hi,
    input wire logic i_byte_order_ident,
    input wire logic i_transfer_direction_in,
    input wire logic [7:0] i_host_byte_bus,
    output logic [7:0] o_host_byte_bus,
    output logic o_host_byte_bus_oe,
    output logic o_port_ready_out,
    output logic o_core_to_host_irq_n,
    // Core side
    output logic o_host_to_core_irq,
    output logic o_shared_access_sel,
    input wire logic i_core_core_to_host_irq_set,
    input wire logic i_core_shared_wr,
    input wire logic i_core_shared_val,
    input wire logic i_core_mem_en,
    input wire logic i_core_mem_we,
    input wire logic [`MEM_IDX_W-1:0] i_core_mem_addr,
    input wire logic [DATA_W-1:0] i_core_mem_wdata,
    output logic [DATA_W-1:0] o_core_mem_rdata
);
    localparam int FW = `MEM_IDX_W + DATA_W;
    logic [DATA_W-1:0] mem [MEM_WORDS];
    logic strobe_act;
    logic strobe_d;
    logic strobe_start;
    logic as_d;
    logic as_fall;
    logic as_valid;
    host_byte_port_pkg::reg_sel_t as_sel;
    logic as_ident;
    logic as_dir;
    host_byte_port_pkg::reg_sel_t acc_sel;
    logic acc_ident;
    logic acc_dir;
    host_byte_port_pkg::reg_sel_t cur_sel;
    logic cur_ident;
    logic cur_dir;
    logic go;
    logic busy;
    logic is_data;
    logic [`PTR_W-1:0] ptr;
    logic [`PTR_W-1:0] next_ptr;
    logic [7:0] hold;
    logic [DATA_W-1:0] word_in;
    logic [DATA_W-1:0] rd_latch;
    logic [DATA_W-1:0] mem_q;
    logic first_byte_low_sel;
    logic shared_sel;
    logic core_to_host_irq;
    logic init_done;
    logic [7:0] ctrl_byte;
    logic [DATA_W-1:0] sel_word;
    logic pf_pend;
    logic [`MEM_IDX_W-1:0] pf_addr;
    host_byte_port_pkg::eng_state_t eng;
    logic core_hold;
    logic f_valid;
    logic f_ready;
    logic [FW-1:0] f_data;
    logic d_valid;
    logic [FW-1:0] d_data;
    logic f_push;

    // The exclusive-NOR output is active low, so only one low strobe counts.
    assign strobe_act = ~i_port_select_n
        & (i_data_strobe_a ^ i_data_strobe_b);
    assign strobe_start = strobe_act & ~strobe_d;
    assign as_fall = as_d & ~i_addr_strobe_n;
    assign cur_sel = as_valid ? as_sel
        : {i_reg_select_hi, i_reg_select_lo};
    assign cur_ident = as_valid ? as_ident : i_byte_order_ident;
    assign cur_dir = as_valid ? as_dir : i_transfer_direction_in;
    assign busy = d_valid | pf_pend
        | (eng != host_byte_port_pkg::ENG_IDLE);
    // Accesses arriving while busy are dropped; the host must honour ready.
    assign go = strobe_start & ~busy;
    assign is_data = (cur_sel == `SEL_DATA_INC)
        || (cur_sel == `SEL_DATA_KEEP);
    assign o_port_ready_out = i_port_select_n | ~busy;
    assign o_core_to_host_irq_n = ~core_to_host_irq;
    assign o_shared_access_sel = shared_sel;
    assign word_in = first_byte_low_sel ? {i_host_byte_bus, hold}
        : {hold, i_host_byte_bus};
    assign next_ptr = ptr + `PTR_STEP;
    assign core_hold = i_core_mem_en & shared_sel;
    assign f_valid = go && cur_dir == `DIR_WRITE && is_data
        && cur_ident == `BYTE_SECOND;
    assign f_data = {(cur_sel == `SEL_DATA_INC) ? next_ptr[`MEM_IDX_W-1:0]
        : ptr[`MEM_IDX_W-1:0], word_in};
    assign f_push = f_valid & f_ready;
    // Direction is only trusted once the take edge has latched it, so a
    // write never sees the port drive against the host for one cycle.
    assign o_host_byte_bus_oe = strobe_act & strobe_d
        & (acc_dir == `DIR_READ);
    assign ctrl_byte = {4'h0, core_to_host_irq, 1'h0, shared_sel, first_byte_low_sel};

    always_comb
    begin
        if (acc_sel == `SEL_PTR)
        begin
            sel_word = ptr;
        end
        else if (acc_sel == `SEL_CTRL)
        begin
            sel_word = {ctrl_byte, ctrl_byte};
        end
        else
        begin
            sel_word = rd_latch;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            strobe_d <= 1'h0;
            as_d <= 1'h1;
        end
        else
        begin
            strobe_d <= strobe_act;
            as_d <= i_addr_strobe_n;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            as_valid <= 1'h0;
            as_sel <= `SEL_CTRL;
            as_ident <= `BYTE_FIRST;
            as_dir <= `DIR_READ;
        end
        else if (as_fall)
        begin
            as_valid <= 1'h1;
            as_sel <= {i_reg_select_hi, i_reg_select_lo};
            as_ident <= i_byte_order_ident;
            as_dir <= i_transfer_direction_in;
        end
        else if (strobe_start)
        begin
            as_valid <= 1'h0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            acc_sel <= `SEL_CTRL;
            acc_ident <= `BYTE_FIRST;
            acc_dir <= `DIR_READ;
        end
        else if (strobe_start)
        begin
            acc_sel <= cur_sel;
            acc_ident <= cur_ident;
            acc_dir <= cur_dir;
        end
    end

    // Read bytes are registered from the latched access fields, so they settle two cycles into the strobe.
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_host_byte_bus <= 8'h00;
        end
        else if ((acc_ident == `BYTE_FIRST) != first_byte_low_sel)
        begin
            o_host_byte_bus <= sel_word[15:8];
        end
        else
        begin
            o_host_byte_bus <= sel_word[7:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            hold <= 8'h00;
        end
        else if (go && cur_dir == `DIR_WRITE && cur_ident == `BYTE_FIRST)
        begin
            hold <= i_host_byte_bus;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            ptr <= `PTR_RST;
        end
        else if (go && cur_ident == `BYTE_SECOND)
        begin
            if (cur_sel == `SEL_PTR && cur_dir == `DIR_WRITE)
            begin
                ptr <= word_in;
            end
            else if (cur_sel == `SEL_DATA_INC)
            begin
                ptr <= next_ptr;
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            pf_pend <= 1'h0;
            pf_addr <= '0;
        end
        else if (go && cur_ident == `BYTE_SECOND
            && ((cur_sel == `SEL_PTR && cur_dir == `DIR_WRITE)
            || (is_data && cur_dir == `DIR_READ)))
        begin
            pf_pend <= 1'h1;
            if (cur_sel == `SEL_PTR)
            begin
                pf_addr <= word_in[`MEM_IDX_W-1:0];
            end
            else if (cur_sel == `SEL_DATA_INC)
            begin
                pf_addr <= next_ptr[`MEM_IDX_W-1:0];
            end
            else
            begin
                pf_addr <= ptr[`MEM_IDX_W-1:0];
            end
        end
        else if (eng == host_byte_port_pkg::ENG_READ)
        begin
            pf_pend <= 1'h0;
        end
    end

    // Prefetch waits for queued writes so it never reads stale words.
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            eng <= host_byte_port_pkg::ENG_IDLE;
        end
        else
        begin
            case (eng)
                host_byte_port_pkg::ENG_IDLE:
                    if (pf_pend && !d_valid && !core_hold)
                    begin
                        eng <= host_byte_port_pkg::ENG_READ;
                    end
                host_byte_port_pkg::ENG_READ:
                    eng <= host_byte_port_pkg::ENG_LOAD;
                default:
                    eng <= host_byte_port_pkg::ENG_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_sys_clk)
    begin
        if (eng == host_byte_port_pkg::ENG_READ)
        begin
            mem_q <= mem[pf_addr];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            rd_latch <= '0;
        end
        else if (f_push)
        begin
            rd_latch <= word_in;
        end
        else if (eng == host_byte_port_pkg::ENG_LOAD)
        begin
            rd_latch <= mem_q;
        end
    end

    // The core owns the memory when it asks while shared access is selected; host writes then queue up.
    always_ff @(posedge i_sys_clk)
    begin
        if (core_hold && i_core_mem_we)
        begin
            mem[i_core_mem_addr] <= i_core_mem_wdata;
        end
        else if (d_valid && !core_hold)
        begin
            mem[d_data[FW-1:DATA_W]] <= d_data[DATA_W-1:0];
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            o_core_mem_rdata <= '0;
        end
        else if (core_hold && !i_core_mem_we)
        begin
            o_core_mem_rdata <= mem[i_core_mem_addr];
        end
    end

    word_fifo #(
        .WIDTH(FW),
        .DEPTH(`FIFO_DEPTH)
    ) u_wr_fifo (
        .i_sys_clk(i_sys_clk),
        .i_rst(i_rst),
        .i_valid(f_valid),
        .o_ready(f_ready),
        .i_data(f_data),
        .o_valid(d_valid),
        .i_ready(~core_hold),
        .o_data(d_data)
    );

    // Control bits; reserved and zero-defined bits are simply not stored.
    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            first_byte_low_sel <= `BOB_RST;
            o_host_to_core_irq <= 1'h0;
        end
        else
        begin
            o_host_to_core_irq <= go && cur_sel == `SEL_CTRL
                && cur_dir == `DIR_WRITE
                && i_host_byte_bus[`CTL_CORE_IRQ];
            if (go && cur_sel == `SEL_CTRL && cur_dir == `DIR_WRITE)
            begin
                first_byte_low_sel <= i_host_byte_bus[`CTL_BOB];
            end
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            core_to_host_irq <= `CORE_TO_HOST_IRQ_RST;
        end
        else if (i_core_core_to_host_irq_set)
        begin
            core_to_host_irq <= 1'h1;
        end
        else if (go && cur_sel == `SEL_CTRL && cur_dir == `DIR_WRITE
            && i_host_byte_bus[`CTL_CORE_TO_HOST_IRQ])
        begin
            core_to_host_irq <= 1'h0;
        end
    end

    always_ff @(posedge i_sys_clk or posedge i_rst)
    begin
        if (i_rst)
        begin
            shared_sel <= `SHARED_IN_RST;
            init_done <= 1'h0;
        end
        else
        begin
            init_done <= 1'h1;
            if (!init_done)
            begin
                shared_sel <= `SHARED_AFTER_RST;
            end
            else if (i_core_shared_wr)
            begin
                shared_sel <= i_core_shared_val;
            end
        end
    end

    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_rst);

    ready_gate_a: assert property (i_port_select_n |-> o_port_ready_out)
        else $error("ready low while deselected");
    strobe_low_a: assert property (
        (!i_data_strobe_a && !i_data_strobe_b) |-> !strobe_act)
        else $error("both strobes low taken as access");
    busy_write_a: assert property (
        f_push |=> !o_port_ready_out || i_port_select_n)
        else $error("ready high after data write");
    ptr_inc_a: assert property (
        (go && cur_sel == `SEL_DATA_INC && cur_ident == `BYTE_SECOND)
        |=> ptr == $past(ptr) + `PTR_STEP)
        else $error("pointer not incremented");
    ptr_keep_a: assert property (
        (go && cur_sel == `SEL_DATA_KEEP) |=> ptr == $past(ptr))
        else $error("pointer moved on plain data access");
    ptr_load_a: assert property (
        (go && cur_sel == `SEL_PTR && cur_dir == `DIR_WRITE
        && cur_ident == `BYTE_SECOND && first_byte_low_sel)
        |=> ptr[15:8] == $past(i_host_byte_bus))
        else $error("pointer byte order wrong");
    irq_pulse_a: assert property (
        (go && cur_sel == `SEL_CTRL && cur_dir == `DIR_WRITE
        && i_host_byte_bus[`CTL_CORE_IRQ])
        |=> o_host_to_core_irq ##1 !o_host_to_core_irq)
        else $error("core interrupt not a single pulse");
    core_to_host_irq_clear_a: assert property (
        (go && cur_sel == `SEL_CTRL && cur_dir == `DIR_WRITE
        && i_host_byte_bus[`CTL_CORE_TO_HOST_IRQ] && !i_core_core_to_host_irq_set)
        |=> o_core_to_host_irq_n)
        else $error("host interrupt not cleared");
    ctrl_zero_a: assert property (
        ($past(acc_sel) == `SEL_CTRL && o_host_byte_bus_oe)
        |-> !o_host_byte_bus[`CTL_CORE_IRQ]
        && o_host_byte_bus[`CTL_RSVD_HI:`CTL_RSVD_LO] == 4'h0)
        else $error("zero control bit read as one");
    as_hold_a: assert property (
        as_fall |=> as_valid && as_sel == $past(
        {i_reg_select_hi, i_reg_select_lo}))
        else $error("address strobe fields not held");
    pf_done_a: assert property (
        (eng == host_byte_port_pkg::ENG_READ)
        |-> ##2 (rd_latch == $past(mem_q)))
        else $error("prefetch not loaded");

    data_write_c: cover property (f_push ##[1:20] !busy);
    data_read_c: cover property (eng == host_byte_port_pkg::ENG_LOAD);
    as_used_c: cover property (as_fall ##[1:10] go);
    fifo_stall_c: cover property (d_valid && core_hold);
endmodule : host_byte_port

`default_nettype wire

// *** testbench/host_cpu_model.sv ***
// Host processor model that drives the byte port pins one byte at a time.
`timescale 1ns/1ps
`default_nettype none
module host_cpu_model (
    // Clock
    input wire logic i_sys_clk,
    // Answers from the port
    input wire logic i_ready,
    input wire logic [7:0] i_rd_byte,
    input wire logic i_rd_oe,
    // Host pins
    output logic o_cs_n,
    output logic o_stb_a,
    output logic o_stb_b,
    output logic o_as_n,
    output logic o_sel_lo,
    output logic o_sel_hi,
    output logic o_ident,
    output logic o_dir,
    output logic [7:0] o_wr_byte
);
    initial
    begin
        {o_cs_n, o_stb_a, o_stb_b, o_as_n} = 4'hf;
        {o_sel_hi, o_sel_lo, o_ident, o_dir, o_wr_byte} = 12'h100;
    end

    // Mode 0 plain, 1 strobe before select, 2 both strobes low, 3 latch.
    task automatic xfer(input logic [1:0] sel, input logic ident,
        input logic dir, input logic [7:0] wd, input int mode,
        output logic [7:0] rd, output logic oe);
        int n;
        @(posedge i_sys_clk);
        #1;
        {o_sel_hi, o_sel_lo, o_ident, o_dir, o_wr_byte} = {sel, ident, dir, wd};
        if (mode == 1)
        begin
            {o_stb_a, o_stb_b} = 2'h2;
            @(posedge i_sys_clk);
            #1;
            o_cs_n = 1'h0;
        end
        else
        begin
            o_cs_n = 1'h0;
            n = 0;
            // Ready only means something once select is low.
            do
            begin
                @(negedge i_sys_clk);
                n++;
            end while (i_ready !== 1'h1 && n < 64);
            @(posedge i_sys_clk);
            #1;
            if (mode == 3)
            begin
                o_as_n = 1'h0;
                @(posedge i_sys_clk);
                #1;
                o_as_n = 1'h1;
                {o_sel_hi, o_sel_lo, o_ident, o_dir} = ~{sel, ident, dir};
            end
            {o_stb_a, o_stb_b} = (mode == 2) ? 2'h0 : 2'h1;
        end
        repeat (3) @(posedge i_sys_clk);
        #1;
        rd = i_rd_byte;
        oe = i_rd_oe;
        {o_cs_n, o_stb_a, o_stb_b} = 3'h7;
        // A released bus does not keep the last byte.
        o_wr_byte = ~o_wr_byte;
    endtask : xfer

    task automatic word(input logic [1:0] sel, input logic dir,
        input logic [15:0] wd, input logic first_byte_low_sel, input int mode,
        output logic [15:0] rd, output logic oe);
        logic [7:0] first_b;
        logic [7:0] second_b;
        logic oe_a;
        logic oe_b;
        xfer(sel, 1'h0, dir, first_byte_low_sel ? wd[7:0] : wd[15:8], mode, first_b, oe_a);
        xfer(sel, 1'h1, dir, first_byte_low_sel ? wd[15:8] : wd[7:0], mode, second_b, oe_b);
        rd = first_byte_low_sel ? {second_b, first_b} : {first_b, second_b};
        oe = oe_a & oe_b;
    endtask : word
endmodule : host_cpu_model
`default_nettype wire

// *** testbench/testbench.sv ***
// Self-checking testbench for the host byte port.
`timescale 1ns/1ps
`include "host_byte_port_consts.svh"
`default_nettype none
module testbench;
    logic i_sys_clk, i_rst, cs_n, stb_a, stb_b, as_n, sel_lo, sel_hi;
    logic ident, dir, oe, ready, irq_n, core_irq, shared_out, first_byte_low_sel, rd_oe;
    logic core_to_host_irq_set, shared_wr, shared_val, mem_en, mem_we;
    logic [7:0] wbyte, rbyte;
    logic [`MEM_IDX_W-1:0] mem_addr;
    logic [15:0] mem_wdata, mem_rdata, rd;
    int failures = 0;
    int n_tests = 0;
    int busy_lo = 0;
    int irq_cnt = 0;

    host_byte_port dut (
        .i_sys_clk(i_sys_clk), .i_rst(i_rst), .i_port_select_n(cs_n),
        .i_data_strobe_a(stb_a), .i_data_strobe_b(stb_b),
        .i_addr_strobe_n(as_n), .i_reg_select_lo(sel_lo),
        .i_reg_select_hi(sel_hi), .i_byte_order_ident(ident),
        .i_transfer_direction_in(dir), .i_host_byte_bus(wbyte),
        .o_host_byte_bus(rbyte), .o_host_byte_bus_oe(oe),
        .o_port_ready_out(ready), .o_core_to_host_irq_n(irq_n),
        .o_host_to_core_irq(core_irq), .o_shared_access_sel(shared_out),
        .i_core_core_to_host_irq_set(core_to_host_irq_set), .i_core_shared_wr(shared_wr),
        .i_core_shared_val(shared_val), .i_core_mem_en(mem_en),
        .i_core_mem_we(mem_we), .i_core_mem_addr(mem_addr),
        .i_core_mem_wdata(mem_wdata), .o_core_mem_rdata(mem_rdata));

    host_cpu_model host (
        .i_sys_clk(i_sys_clk), .i_ready(ready), .i_rd_byte(rbyte),
        .i_rd_oe(oe), .o_cs_n(cs_n), .o_stb_a(stb_a), .o_stb_b(stb_b),
        .o_as_n(as_n), .o_sel_lo(sel_lo), .o_sel_hi(sel_hi),
        .o_ident(ident), .o_dir(dir), .o_wr_byte(wbyte));

    initial
    begin
        i_sys_clk = 1'h0;
        forever #20 i_sys_clk = ~i_sys_clk;
    end

    task automatic give_verdict;
        if (failures == 0 && n_tests > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : give_verdict

    task automatic check(input string what, input logic [15:0] seen,
        input logic [15:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    always @(negedge i_sys_clk)
    begin
        if (cs_n === 1'h1)
            check("ready deselected", {15'h0, ready}, 16'h1);
        if (cs_n === 1'h0 && ready === 1'h0)
            busy_lo++;
        if (core_irq === 1'h1)
            irq_cnt++;
    end

    task automatic hw(input logic [1:0] sel, input logic d,
        input logic [15:0] wd, input int mode);
        host.word(sel, d, wd, first_byte_low_sel, mode, rd, rd_oe);
    endtask : hw

    task automatic ctl(input logic [7:0] v);
        first_byte_low_sel = v[0];
        hw(`SEL_CTRL, `DIR_WRITE, {v, v}, 0);
    endtask : ctl

    task automatic core_op(input logic we, input logic [10:0] a,
        input logic [15:0] d);
        @(posedge i_sys_clk);
        #1;
        {mem_en, mem_we, mem_addr, mem_wdata} = {1'h1, we, a, d};
        @(posedge i_sys_clk);
        #1;
        {mem_en, mem_we} = 2'h0;
    endtask : core_op

    task automatic core_ctl(input logic [2:0] v);
        @(posedge i_sys_clk);
        #1;
        {core_to_host_irq_set, shared_wr, shared_val} = v;
        @(posedge i_sys_clk);
        #1;
        {core_to_host_irq_set, shared_wr, shared_val} = 3'h0;
    endtask : core_ctl

    task automatic t_ctrl;
        check("shared after reset", {15'h0, shared_out}, 16'h1);
        hw(`SEL_CTRL, `DIR_READ, 16'h0, 0);
        check("control reset", rd, 16'h0202);
        ctl(8'hf1);
        hw(`SEL_CTRL, `DIR_READ, 16'h0, 0);
        check("control reserved", rd, 16'h0303);
        check("no core irq", irq_cnt[15:0], 16'h0);
        ctl(8'h05);
        hw(`SEL_CTRL, `DIR_READ, 16'h0, 0);
        check("core irq bit", rd, 16'h0303);
        check("core irq raised", {15'h0, irq_cnt != 0}, 16'h1);
    endtask : t_ctrl

    task automatic t_core_to_host_irq;
        core_ctl(3'h4);
        check("irq pin set", {15'h0, irq_n}, 16'h0);
        hw(`SEL_CTRL, `DIR_READ, 16'h0, 0);
        check("core_to_host_irq read", rd, 16'h0b0b);
        ctl(8'h01);
        check("irq pin kept", {15'h0, irq_n}, 16'h0);
        ctl(8'h09);
        check("irq pin cleared", {15'h0, irq_n}, 16'h1);
        core_ctl(3'h2);
        hw(`SEL_CTRL, `DIR_READ, 16'h0, 0);
        check("shared cleared", rd, 16'h0101);
        core_ctl(3'h3);
    endtask : t_core_to_host_irq

    task automatic t_data;
        hw(`SEL_PTR, `DIR_WRITE, 16'hffff, 0);
        busy_lo = 0;
        hw(`SEL_DATA_INC, `DIR_WRITE, 16'h1234, 0);
        check("write busy", {15'h0, busy_lo != 0}, 16'h1);
        core_op(1'h0, 11'h0, 16'h0);
        check("mem after wrap", mem_rdata, 16'h1234);
        hw(`SEL_DATA_KEEP, `DIR_WRITE, 16'h5678, 0);
        core_op(1'h0, 11'h0, 16'h0);
        check("mem keep", mem_rdata, 16'h5678);
        hw(`SEL_PTR, `DIR_READ, 16'h0, 0);
        check("ptr wrapped", rd, 16'h0000);
        ctl(8'h00);
        hw(`SEL_PTR, `DIR_WRITE, 16'h07ff, 0);
        hw(`SEL_DATA_INC, `DIR_WRITE, 16'habcd, 0);
        core_op(1'h0, 11'h0, 16'h0);
        check("mem msb first", mem_rdata, 16'habcd);
        hw(`SEL_PTR, `DIR_READ, 16'h0, 0);
        check("ptr pre inc", rd, 16'h0800);
    endtask : t_data

    task automatic t_read;
        ctl(8'h01);
        core_op(1'h1, 11'h010, 16'hbeef);
        core_op(1'h1, 11'h011, 16'hcafe);
        hw(`SEL_PTR, `DIR_WRITE, 16'h0810, 0);
        hw(`SEL_DATA_INC, `DIR_READ, 16'h0, 0);
        check("read alias", rd, 16'hbeef);
        check("read drives bus", {15'h0, rd_oe}, 16'h1);
        hw(`SEL_DATA_KEEP, `DIR_READ, 16'h0, 0);
        check("read post inc", rd, 16'hcafe);
        hw(`SEL_PTR, `DIR_READ, 16'h0, 0);
        check("ptr kept", rd, 16'h0811);
        hw(`SEL_DATA_KEEP, `DIR_WRITE, 16'h4321, 0);
        hw(`SEL_DATA_KEEP, `DIR_READ, 16'h0, 0);
        check("read after write", rd, 16'h4321);
    endtask : t_read

    task automatic t_modes;
        hw(`SEL_PTR, `DIR_WRITE, 16'h0001, 1);
        hw(`SEL_PTR, `DIR_READ, 16'h0, 0);
        check("select last", rd, 16'h0001);
        hw(`SEL_PTR, `DIR_WRITE, 16'h7777, 2);
        hw(`SEL_PTR, `DIR_READ, 16'h0, 0);
        check("both strobes low", rd, 16'h0001);
        hw(`SEL_PTR, `DIR_WRITE, 16'h0123, 3);
        hw(`SEL_PTR, `DIR_READ, 16'h0, 0);
        check("address strobe", rd, 16'h0123);
    endtask : t_modes

    initial
    begin
        i_rst = 1'h1;
        first_byte_low_sel = 1'h0;
        {core_to_host_irq_set, shared_wr, shared_val, mem_en, mem_we} = 5'h0;
        mem_addr = 11'h0;
        mem_wdata = 16'h0;
        @(posedge i_sys_clk);
        @(negedge i_sys_clk);
        check("ready in reset", {15'h0, ready}, 16'h1);
        check("irq pin in reset", {15'h0, irq_n}, 16'h1);
        check("shared in reset", {15'h0, shared_out}, 16'h0);
        @(posedge i_sys_clk);
        #1;
        i_rst = 1'h0;
        repeat (2) @(posedge i_sys_clk);
        #1;
        t_ctrl;
        t_core_to_host_irq;
        t_data;
        t_read;
        t_modes;
        give_verdict;
    end

    // The whole sequence needs well under two thousand cycles.
    initial
    begin
        repeat (20000) @(posedge i_sys_clk);
        failures++;
        give_verdict;
    end
endmodule : testbench
`default_nettype wire
